// ===== logic/gpp_port_top.sv
// Summary of operation
// - Pin read gives pins; pin write loads latch
// - Direction one makes pin input, driver off
// - Direction zero drives latch value onto pin
// - Latch read returns latched values, not pins
// - Enabled peripheral takes over its shared pin
// - Nine ports, each direction, level, latch
// - Four ports have one pull-up enable each
// - B enable control-two bit7; D,E,J pad 7:5
// - Enabled pull-ups follow latch; disabled all off
// - Select 00 alarm, 01 seconds, 10 oscillator
// - Clock pin shows source only when enabled
// - Pad bits 4:3 and 0 read zero
// - Small variant: port J enable reads zero
// - Open-drain option per peripheral control bit
module gpp_port_top
  import gpp_pkg::*;
#(
  parameter bit          SMALL_VARIANT = 1'b0,           // Smaller pin-count part
  parameter int unsigned NUM_PORTS     = PORT_COUNT      // Ports built
)
(
  input  wire logic                              aclk,
  input  wire logic                              aresetn,
  input  wire logic [11:0]                       s_axi_awaddr,
  input  wire logic                              s_axi_awvalid,
  output logic                                   s_axi_awready,
  input  wire logic [31:0]                       s_axi_wdata,
  input  wire logic [3:0]                        s_axi_wstrb,
  input  wire logic                              s_axi_wvalid,
  output logic                                   s_axi_wready,
  output logic [1:0]                             s_axi_bresp,
  output logic                                   s_axi_bvalid,
  input  wire logic                              s_axi_bready,
  input  wire logic [11:0]                       s_axi_araddr,
  input  wire logic                              s_axi_arvalid,
  output logic                                   s_axi_arready,
  output logic [31:0]                            s_axi_rdata,
  output logic [1:0]                             s_axi_rresp,
  output logic                                   s_axi_rvalid,
  input  wire logic                              s_axi_rready,
  input  wire logic [NUM_PORTS*PORT_WIDTH-1:0]   pin_in,
  output logic      [NUM_PORTS*PORT_WIDTH-1:0]   pin_out,
  output logic      [NUM_PORTS*PORT_WIDTH-1:0]   pin_oe_n,
  output logic      [NUM_PORTS*PORT_WIDTH-1:0]   pin_pullup,
  input  wire logic [NUM_PORTS*PORT_WIDTH-1:0]   periph_map,
  input  wire logic [NUM_PORTS*PORT_WIDTH-1:0]   periph_out,
  input  wire logic [NUM_PORTS*PORT_WIDTH-1:0]   periph_oe,
  input  wire logic [NUM_PORTS*PORT_WIDTH*4-1:0] periph_od_slot,
  input  wire logic                              rtc_alarm_pulse,
  input  wire logic                              rtc_seconds_clk,
  input  wire logic                              rtc_source_osc,
  output logic                                   rtc_pin
);
  localparam int unsigned NPINS = NUM_PORTS * PORT_WIDTH;  // Total pins

  // Elaboration check on port count
  if (NUM_PORTS != PORT_COUNT)
    $error("gpp_port_top: NUM_PORTS must equal PORT_COUNT");

  logic [PORT_WIDTH-1:0] direction_reg    [NUM_PORTS];  // One means input
  logic [PORT_WIDTH-1:0] output_latch_reg [NUM_PORTS];  // Output latches
  logic [7:0]            pad_configuration;             // Pull-ups and clock select
  logic [7:0]            interrupt_control_two;         // Bit 7 is port B pull-up
  logic [7:0]            open_drain_ctrl_one;           // Serial port open-drain bits
  logic [7:0]            open_drain_ctrl_two;           // Capture/compare open-drain bits
  logic [7:0]            open_drain_ctrl_three;         // Async serial open-drain bits
  logic                  rtc_pin_out_en;                // Clock pin output enable
  logic [NPINS-1:0]      periph_enable;                 // Software pin takeover mask
  logic [NPINS-1:0]      pin_level;                     // Synchronised pin levels
  logic [PERIPH_COUNT-1:0] od_vec;                      // Flattened open-drain bits

  logic [11:0] wr_addr;   // Captured write address
  logic [31:0] wr_data;   // Captured write data
  logic [3:0]  wr_strb;   // Captured strobes
  logic        have_aw;   // Address held
  logic        have_w;    // Data held
  logic        wr_go;     // Both halves present
  logic        wr_hit;    // Address decoded
  logic [31:0] rd_word;   // Decoded read value
  logic        rd_hit;    // Read address decoded

  // Pin input synchronisers
  gpp_pin_sync #(.WIDTH(NPINS)) u_sync
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_in  (pin_in),
    .level   (pin_level)
  );

  assign wr_go = have_aw && have_w && !s_axi_bvalid;

  // Write address and data capture, either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      have_aw       <= 1'b0;
      have_w        <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      wr_addr       <= '0;
      wr_data       <= '0;
      wr_strb       <= '0;
    end
    else
    begin
      // No new address or data while a response is still pending
      s_axi_awready <= !have_aw && !s_axi_awready && !wr_go && !s_axi_bvalid;
      s_axi_wready  <= !have_w && !s_axi_wready && !wr_go && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        have_aw <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        have_w  <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        have_aw <= 1'b0;
        have_w  <= 1'b0;
      end
    end
  end

  // Write address decode
  always_comb
  begin
    wr_hit = 1'b0;
    if (wr_addr < 12'(NUM_PORTS * PORT_STRIDE))
      wr_hit = (wr_addr[3:0] == OFS_DIRECTION[3:0]) || (wr_addr[3:0] == OFS_PIN_LEVEL[3:0])
            || (wr_addr[3:0] == OFS_LATCH[3:0]);
    else
      case (wr_addr)
        OFS_PAD_CFG, OFS_INT_CTL2, OFS_OD_CTL1, OFS_OD_CTL2,
        OFS_OD_CTL3, OFS_RTC_CTL, OFS_PERIPH_EN: wr_hit = 1'b1;
        default:                                  wr_hit = 1'b0;
      endcase
  end

  // Write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Per-port direction and latch registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int p = 0; p < NUM_PORTS; p++)
      begin
        direction_reg[p]    <= DIR_RESET;
        output_latch_reg[p] <= REG_RESET;
      end
    end
    else if (wr_go && wr_strb[0] && wr_addr < 12'(NUM_PORTS * PORT_STRIDE))
    begin
      // Pin-level and latch writes both land in the latch
      if (wr_addr[3:0] == OFS_DIRECTION[3:0])
        direction_reg[wr_addr[7:4]] <= wr_data[7:0];
      else if (wr_addr[3:0] == OFS_PIN_LEVEL[3:0] || wr_addr[3:0] == OFS_LATCH[3:0])
        output_latch_reg[wr_addr[7:4]] <= wr_data[7:0];
    end
  end

  // Global configuration registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pad_configuration     <= PAD_RESET;
      interrupt_control_two <= REG_RESET;
      open_drain_ctrl_one   <= REG_RESET;
      open_drain_ctrl_two   <= REG_RESET;
      open_drain_ctrl_three <= REG_RESET;
      rtc_pin_out_en        <= 1'b0;
      periph_enable         <= '0;
    end
    else if (wr_go && wr_strb[0])
    begin
      case (wr_addr)
        OFS_PAD_CFG:
        begin
          // Unimplemented bits stay zero; J enable absent on small part
          pad_configuration <= wr_data[7:0] & PAD_WR_MASK
                               & ~(SMALL_VARIANT ? 8'h20 : 8'h00);
        end
        OFS_INT_CTL2:  interrupt_control_two <= wr_data[7:0];
        OFS_OD_CTL1:   open_drain_ctrl_one   <= wr_data[7:0] & OD1_WR_MASK;
        OFS_OD_CTL2:   open_drain_ctrl_two   <= wr_data[7:0] & OD2_WR_MASK;
        OFS_OD_CTL3:   open_drain_ctrl_three <= wr_data[7:0] & OD3_WR_MASK;
        OFS_RTC_CTL:   rtc_pin_out_en        <= wr_data[0];
        // Only the low 32 pins can be taken over from the bus word
        OFS_PERIPH_EN: periph_enable         <= {{(NPINS-32){1'b0}}, wr_data} & periph_map;
        default:       ;
      endcase
    end
  end

  // Read decode
  always_comb
  begin
    rd_word = '0;
    rd_hit  = 1'b1;
    if (s_axi_araddr < 12'(NUM_PORTS * PORT_STRIDE))
    begin
      case (s_axi_araddr[3:0])
        OFS_DIRECTION[3:0]: rd_word[7:0] = direction_reg[s_axi_araddr[7:4]];
        OFS_PIN_LEVEL[3:0]: rd_word[7:0] = pin_level[s_axi_araddr[7:4]*PORT_WIDTH +: PORT_WIDTH];
        OFS_LATCH[3:0]:     rd_word[7:0] = output_latch_reg[s_axi_araddr[7:4]];
        default:            rd_hit = 1'b0;
      endcase
    end
    else
      case (s_axi_araddr)
        OFS_PAD_CFG:   rd_word[7:0] = pad_configuration;
        OFS_INT_CTL2:  rd_word[7:0] = interrupt_control_two;
        OFS_OD_CTL1:   rd_word[7:0] = open_drain_ctrl_one;
        OFS_OD_CTL2:   rd_word[7:0] = open_drain_ctrl_two;
        OFS_OD_CTL3:   rd_word[7:0] = open_drain_ctrl_three;
        OFS_RTC_CTL:   rd_word[0]   = rtc_pin_out_en;
        OFS_PERIPH_EN: rd_word     = periph_enable[31:0];
        default:       rd_hit = 1'b0;
      endcase
  end

  // Read channel: one cycle address accept, then data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Peripheral open-drain slots gathered in one vector
  assign od_vec = {open_drain_ctrl_three[7:6], open_drain_ctrl_two, open_drain_ctrl_one[7:5],
                   open_drain_ctrl_one[0], 2'b00};

  // Pin drivers, pull-ups
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_out    <= '0;
      pin_oe_n   <= '1;
      pin_pullup <= '0;
    end
    else
    begin
      for (int i = 0; i < NPINS; i++)
      begin
        // Peripheral takes the pin when enabled
        if (periph_enable[i])
        begin
          pin_out[i] <= 1'b0;
          if (od_vec[periph_od_slot[i*4 +: 4]])
            pin_oe_n[i] <= !(periph_oe[i] && !periph_out[i]);
          else
          begin
            pin_out[i]  <= periph_out[i];
            pin_oe_n[i] <= !periph_oe[i];
          end
        end
        else
        begin
          pin_out[i]  <= output_latch_reg[i/PORT_WIDTH][i%PORT_WIDTH];
          pin_oe_n[i] <= direction_reg[i/PORT_WIDTH][i%PORT_WIDTH];
        end
        pin_pullup[i] <= 1'b0;
      end
      // Per-port pull-ups follow latch when the port enable is set
      for (int b = 0; b < PORT_WIDTH; b++)
      begin
        pin_pullup[PORT_B*PORT_WIDTH+b] <= interrupt_control_two[INT2_PU_B_BIT]
                                           && output_latch_reg[PORT_B][b];
        pin_pullup[PORT_D*PORT_WIDTH+b] <= pad_configuration[PAD_PU_D_BIT]
                                           && output_latch_reg[PORT_D][b];
        pin_pullup[PORT_E*PORT_WIDTH+b] <= pad_configuration[PAD_PU_E_BIT]
                                           && output_latch_reg[PORT_E][b];
        pin_pullup[PORT_J*PORT_WIDTH+b] <= pad_configuration[PAD_PU_J_BIT]
                                           && output_latch_reg[PORT_J][b];
      end
    end
  end

  // Clock pin source selection, gated by its enable
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rtc_pin <= 1'b0;
    else if (!rtc_pin_out_en)
      rtc_pin <= 1'b0;
    else
      case (pad_configuration[PAD_SEL_LSB +: 2])
        RTC_SEL_ALARM: rtc_pin <= rtc_alarm_pulse;
        RTC_SEL_SEC:   rtc_pin <= rtc_seconds_clk;
        RTC_SEL_OSC:   rtc_pin <= rtc_source_osc;
        default:       rtc_pin <= 1'b0;
      endcase
  end
endmodule

// ===== logic/gpp_pkg.sv
package gpp_pkg;
  // Port geometry
  localparam int unsigned PORT_COUNT    = 9;   // Ports A..J (no I)
  localparam int unsigned PORT_WIDTH    = 8;   // Pins per port
  localparam int unsigned PORT_STRIDE   = 16;  // Bytes per port block
  // Per-port register offsets inside a port block
  localparam logic [11:0] OFS_DIRECTION = 12'h000;
  localparam logic [11:0] OFS_PIN_LEVEL = 12'h004;
  localparam logic [11:0] OFS_LATCH     = 12'h008;
  // Global registers, placed after the port blocks
  localparam logic [11:0] OFS_PAD_CFG   = 12'h100;
  localparam logic [11:0] OFS_INT_CTL2  = 12'h104;
  localparam logic [11:0] OFS_OD_CTL1   = 12'h108;
  localparam logic [11:0] OFS_OD_CTL2   = 12'h10C;
  localparam logic [11:0] OFS_OD_CTL3   = 12'h110;
  localparam logic [11:0] OFS_RTC_CTL   = 12'h114;
  localparam logic [11:0] OFS_PERIPH_EN = 12'h118;
  // Port indices that own pull-ups
  localparam int unsigned PORT_B = 1;
  localparam int unsigned PORT_D = 3;
  localparam int unsigned PORT_E = 4;
  localparam int unsigned PORT_J = 8;
  // Pad configuration fields
  localparam int unsigned PAD_PU_D_BIT  = 7;
  localparam int unsigned PAD_PU_E_BIT  = 6;
  localparam int unsigned PAD_PU_J_BIT  = 5;
  localparam int unsigned PAD_SEL_LSB   = 1;
  localparam logic [7:0]  PAD_WR_MASK   = 8'hE6;
  localparam logic [7:0]  PAD_RESET     = 8'h00;
  localparam int unsigned INT2_PU_B_BIT = 7;
  // Open-drain control writable masks
  localparam logic [7:0]  OD1_WR_MASK   = 8'hE1;
  localparam logic [7:0]  OD2_WR_MASK   = 8'hFF;
  localparam logic [7:0]  OD3_WR_MASK   = 8'hC0;
  localparam logic [7:0]  REG_RESET     = 8'h00;
  localparam logic [7:0]  DIR_RESET     = 8'hFF;
  // Peripheral slots with open-drain option (16 slots)
  localparam int unsigned PERIPH_COUNT  = 16;
  // Clock pin source codes
  localparam logic [1:0]  RTC_SEL_ALARM = 2'h0;
  localparam logic [1:0]  RTC_SEL_SEC   = 2'h1;
  localparam logic [1:0]  RTC_SEL_OSC   = 2'h2;
  // AXI responses
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage

// ===== logic/gpp_pin_sync.sv
// Three-stage pin synchroniser; a level change is taken once stages two and three agree
module gpp_pin_sync
  import gpp_pkg::*;
#(
  parameter int unsigned WIDTH = 8
)
(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level
);
  logic [WIDTH-1:0] stage1;  // Metastability catcher
  logic [WIDTH-1:0] stage2;  // Second stage
  logic [WIDTH-1:0] stage3;  // Third stage

  // Shift chain
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end
    else
    begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Accept a bit only when the two later stages agree
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      level <= '0;
    else
      for (int i = 0; i < WIDTH; i++)
        if (stage2[i] == stage3[i])
          level[i] <= stage3[i];
  end
endmodule

// ===== bench/gpp_port_assertions.sv
// Port-level checker for the pad and port block
module gpp_port_assertions
  import gpp_pkg::*;
#(
  parameter int unsigned NUM_PORTS = PORT_COUNT
)
(
  input wire logic                            aclk,
  input wire logic                            aresetn,
  input wire logic                            s_axi_awvalid,
  input wire logic                            s_axi_awready,
  input wire logic                            s_axi_bvalid,
  input wire logic [11:0]                     s_axi_araddr,
  input wire logic                            s_axi_arvalid,
  input wire logic                            s_axi_arready,
  input wire logic [31:0]                     s_axi_rdata,
  input wire logic [1:0]                      s_axi_rresp,
  input wire logic                            s_axi_rvalid,
  input wire logic                            s_axi_rready,
  input wire logic [NUM_PORTS*PORT_WIDTH-1:0] pin_pullup,
  input wire logic                            rtc_alarm_pulse,
  input wire logic                            rtc_seconds_clk,
  input wire logic                            rtc_source_osc,
  input wire logic                            rtc_pin
);
  logic [11:0] rd_addr; // Address of the read under way
  logic        any_src; // Some clock pin source is high

  assign any_src = rtc_alarm_pulse || rtc_seconds_clk || rtc_source_osc;

  // Remember the accepted read address
  always_ff @(posedge aclk)
  begin
    if (!aresetn) rd_addr <= 12'h000;
    else if (s_axi_arvalid && s_axi_arready) rd_addr <= s_axi_araddr;
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_rd_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  property p_rd_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
  property p_wr_answer; s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid; endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
  property p_no_aw_busy; s_axi_bvalid |-> !s_axi_awready; endproperty
  a_no_aw_busy: assert property (p_no_aw_busy) else $error("address taken while busy");
  property p_pad_zero;
    s_axi_rvalid && rd_addr == OFS_PAD_CFG |-> s_axi_rdata[4:3] == 2'h0 && s_axi_rdata[0] == 1'b0;
  endproperty
  a_pad_zero: assert property (p_pad_zero) else $error("pad unused bits set");
  property p_pull_ports; pin_pullup[7:0] == 8'h00 && pin_pullup[23:16] == 8'h00 && pin_pullup[63:40] == 24'h0; endproperty
  a_pull_ports: assert property (p_pull_ports) else $error("pull-up on plain port");
  property p_rtc_src; rtc_pin |-> $past(any_src) || $past(any_src, 2); endproperty
  a_rtc_src: assert property (p_rtc_src) else $error("clock pin high without source");
  property p_rd_unmapped; s_axi_rvalid && rd_addr == 12'hFFC |-> s_axi_rresp == RESP_SLVERR; endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not refused");
endmodule

bind gpp_port_top gpp_port_assertions #(.NUM_PORTS(NUM_PORTS)) u_chk (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .pin_pullup, .rtc_alarm_pulse, .rtc_seconds_clk, .rtc_source_osc, .rtc_pin);

// ===== bench/gpp_pin_world.sv
// Circuitry on the pins: resistors and external drivers
module gpp_pin_world
(
  input  wire logic        aclk,
  input  wire logic [71:0] pin_out,
  input  wire logic [71:0] pin_oe_n,
  input  wire logic [71:0] pin_pullup,
  input  wire logic [71:0] ext_val,
  input  wire logic [71:0] ext_en,
  output logic      [71:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [71:0] float_pat = {36{2'h1}}; // Changing level on floating pins

  // Undriven pins without a pull-up never hold a stable value
  always_ff @(posedge aclk)
    float_pat <= ~float_pat;

  // Device driver wins, then external driver or resistor, then the weak pull-up
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
                | (pin_oe_n & ~ext_en & (pin_pullup | float_pat));
endmodule

// ===== bench/gpp_port_top_test.sv
module gpp_port_top_test
  import gpp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic         aclk = 1'b0, aresetn = 1'b0;
  logic [11:0]  s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0]  s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0]   s_axi_wstrb = 4'h1;
  logic         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]   s_axi_bresp, s_axi_rresp, rsp;
  logic [71:0]  pin_in, pin_out, pin_oe_n, pin_pullup;
  logic [71:0]  periph_map = 72'h0, periph_out = 72'h0, periph_oe = 72'h0, ext_val = 72'h0, ext_en = 72'h0;
  logic [287:0] periph_od_slot = 288'h0;
  logic         rtc_alarm_pulse = 1'b0, rtc_seconds_clk = 1'b0, rtc_source_osc = 1'b0, rtc_pin;
  logic [7:0]   lat [9];                            // Latch written to each port
  logic [7:0]   dir;                                // Direction under test
  logic [7:0]   pads [4] = '{8'hFF, 8'h40, 8'h20, 8'h00}; // Pull-up configurations
  logic [7:0]   ints [4] = '{8'h80, 8'h00, 8'h80, 8'h00};
  int           fail_count = 0, checks = 0, p, k, j;

  gpp_port_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out, .pin_oe_n,
    .pin_pullup, .periph_map, .periph_out, .periph_oe, .periph_od_slot, .rtc_alarm_pulse, .rtc_seconds_clk,
    .rtc_source_osc, .rtc_pin);
  gpp_pin_world u_pins (.aclk, .pin_out, .pin_oe_n, .pin_pullup, .ext_val, .ext_en, .pin_in);

  // 200 MHz clock
  initial forever #2.5 aclk = ~aclk;

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bus write of one byte
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // Wait for the answer; only the watchdog ends a hang
    forever
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask

  // Bus read; ready sometimes raised late
  task automatic rd_reg(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'($urandom_range(1));
    // Wait for the answer; only the watchdog ends a hang
    forever
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready)
      begin
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
      else if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    rd_reg(a);
    chk(rd, exp);
  endtask

  // Clock pin source for a select code
  function automatic logic f_rtc(input logic [1:0] sel, input logic [2:0] src);
    case (sel)
      2'h0: return src[2];
      2'h1: return src[1];
      2'h2: return src[0];
      default: return 1'b0;
    endcase
  endfunction

  // Pull-ups of a port for given enables
  function automatic logic [7:0] f_pull(input int pn, input logic [7:0] pad, input logic [7:0] i2, input logic [7:0] l);
    logic en;
    en = (pn == 1) ? i2[7] : (pn == 3) ? pad[7] : (pn == 4) ? pad[6] : (pn == 8) ? pad[5] : 1'b0;
    return en ? l : 8'h00;
  endfunction

  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    stop_test;
  end

  initial
  begin
    void'($urandom(32'h0195));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(OFS_PAD_CFG, 32'h0);
    rchk(OFS_DIRECTION, 32'hFF);
    chk(pin_oe_n[31:0], 32'hFFFFFFFF);
    $display("Test reset done");
    // Every port: latch via pin-level write, direction, pin readback
    for (p = 0; p < 9; p++)
    begin
      lat[p] = 8'($urandom);
      dir = (p == 0) ? 8'h00 : (p == 1) ? 8'hFF : 8'($urandom);
      ext_val[p*8 +: 8] <= 8'($urandom);
      ext_en[p*8 +: 8] <= dir;
      wr(12'(p*16) + OFS_PIN_LEVEL, lat[p]);
      wr(12'(p*16) + OFS_DIRECTION, dir);
      rchk(12'(p*16) + OFS_LATCH, lat[p]);
      repeat (8) @(posedge aclk);
      chk(pin_oe_n[p*8 +: 8], dir);
      chk(pin_out[p*8 +: 8] & ~dir, lat[p] & ~dir);
      rchk(12'(p*16) + OFS_PIN_LEVEL, (lat[p] & ~dir) | (ext_val[p*8 +: 8] & dir));
      rchk(12'(p*16) + OFS_LATCH, lat[p]);
    end
    $display("Test ports done");
    for (k = 0; k < 4; k++)
    begin
      wr(OFS_PAD_CFG, pads[k]);
      wr(OFS_INT_CTL2, ints[k]);
      rchk(OFS_PAD_CFG, {24'h0, pads[k] & 8'hE6});
      repeat (4) @(posedge aclk);
      for (p = 0; p < 9; p++)
        chk(pin_pullup[p*8 +: 8], f_pull(p, pads[k], ints[k], lat[p]));
    end
    $display("Test pull-ups done");
    wr(OFS_RTC_CTL, 8'h01);
    for (k = 0; k < 4; k++)
    begin
      wr(OFS_PAD_CFG, 8'(k << 1));
      chk(rsp, RESP_OKAY);
      for (j = 0; j < 4; j++)
      begin
        {rtc_alarm_pulse, rtc_seconds_clk, rtc_source_osc} <= 3'($urandom);
        repeat (4) @(posedge aclk);
        chk(rtc_pin, f_rtc(2'(k), {rtc_alarm_pulse, rtc_seconds_clk, rtc_source_osc}));
      end
    end
    wr(OFS_RTC_CTL, 8'h00);
    {rtc_alarm_pulse, rtc_seconds_clk, rtc_source_osc} <= 3'h7;
    repeat (4) @(posedge aclk);
    chk(rtc_pin, 1'b0);
    $display("Test clock pin done");
    wr(12'hFFC, 8'h55);
    chk(rsp, RESP_SLVERR);
    rd_reg(12'hFFC);
    chk(rsp, RESP_SLVERR);
    $display("Test unmapped done");
    // Peripheral on port A pin 2, open-drain slot 2, external resistor high
    periph_map[2] <= 1'b1;
    periph_oe[2] <= 1'b1;
    periph_od_slot[11:8] <= 4'h2;
    ext_en[2] <= 1'b1;
    ext_val[2] <= 1'b1;
    wr(OFS_PERIPH_EN, 8'h04);
    for (j = 0; j < 4; j++)
    begin
      wr(OFS_OD_CTL1, {7'h0, j[1]});
      periph_out[2] <= j[0];
      repeat (4) @(posedge aclk);
      chk(pin_oe_n[2], j[1] & j[0]);
      if (!(j[1] && j[0])) chk(pin_out[2], j[0]);
    end
    wr(OFS_OD_CTL1, 8'hFF);
    rchk(OFS_OD_CTL1, 32'hE1);
    $display("Test open-drain done");
    stop_test;
  end
endmodule
